// *** rtl/osc_cfg_pkg.sv ***
package osc_cfg_pkg;

  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_OSC_CONFIG   = 10'h2fa;
  localparam logic [9:0] IDX_CLK_PROTECT  = 10'h2fb;
  localparam logic [9:0] IDX_FACTORY_TEST = 10'h2fc;
  localparam logic [9:0] IDX_REF_DIVIDE   = 10'h2fd;
  localparam logic [9:0] IDX_INT_STATUS   = 10'h2fe;
  localparam logic [9:0] IDX_INT_MASK     = 10'h2ff;

  localparam int ADDR_W = 12;

  // Field positions
  localparam int OSC_ENABLE_BIT = 7;
  localparam int FLAG_LOCK_BIT  = 0;
  localparam int FLAG_UP_BIT    = 1;
  localparam int MON_EVENT_BIT  = 2;
  localparam int INT_W          = 3;
  localparam int REF_DIVIDER_W       = 4;

  // Reset values
  localparam logic [7:0]          OSC_CONFIG_RST   = 8'h00;
  localparam logic                PROTECT_RST      = 1'b0;
  localparam logic [7:0]          FACTORY_TEST_RST = 8'h00;
  localparam logic [REF_DIVIDER_W-1:0] REF_DIVIDE_RST   = 4'h0;
  localparam logic [INT_W-1:0]    INT_STATUS_RST   = 3'h0;
  localparam logic [INT_W-1:0]    INT_MASK_RST     = 3'h0;

  localparam logic [7:0] UNLOCK_KEY = 8'h26;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic       osc_enable;
    logic       rsvd6;
    logic       spare5;
    logic [4:0] rsvd4_0;
  } osc_cfg_t;

  typedef struct packed {
    logic osc_loss;
    logic osc_stable;
    logic pll_locked;
  } clk_status_t;

  typedef enum logic [2:0] {
    SEL_OSC,
    SEL_PROTECT,
    SEL_TEST,
    SEL_REF_DIVIDER,
    SEL_STATUS,
    SEL_MASK,
    SEL_NONE
  } reg_sel_t;

endpackage

// *** rtl/osc_config_and_write_protect.sv ***
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module osc_config_and_write_protect
  import osc_cfg_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              pll_clock_select,
  input  wire logic              special_mode,
  input  wire clk_status_t       clk_status,
  input  wire logic              internal_rc_clock,
  input  wire logic              osc_output_clock,
  output logic                   crystal_oscillator_enable,
  output logic                   clock_monitor_enable,
  output logic                   osc_qualify_enable,
  output logic                   reference_clock,
  output logic                   clock_monitor_reset,
  output logic                   osc_clock_allowed,
  output logic                   cfg_write_enable,
  output logic [REF_DIVIDER_W-1:0]    ref_divider,
  output logic [7:0]             factory_test_value,
  output logic                   irq
);

  function automatic reg_sel_t decode(input logic [ADDR_W-1:0] addr);
    logic [9:0] idx;
    idx = addr[ADDR_W-1:2];
    if (addr[1:0] != 2'b00)
      decode = SEL_NONE;
    else
    begin
      case (idx)
        IDX_OSC_CONFIG:   decode = SEL_OSC;
        IDX_CLK_PROTECT:  decode = SEL_PROTECT;
        IDX_FACTORY_TEST: decode = SEL_TEST;
        IDX_REF_DIVIDE:   decode = SEL_REF_DIVIDER;
        IDX_INT_STATUS:   decode = SEL_STATUS;
        IDX_INT_MASK:     decode = SEL_MASK;
        default:          decode = SEL_NONE;
      endcase
    end
  endfunction

  logic [ADDR_W-1:0]   awaddr_ff;
  logic                aw_held_ff;
  logic [7:0]          wbyte_ff;
  logic                wlane0_ff;
  logic                w_held_ff;
  logic                bvalid_ff;
  logic [1:0]          bresp_ff;
  logic                rvalid_ff;
  logic [31:0]         rdata_ff;
  logic [1:0]          rresp_ff;
  osc_cfg_t            osc_cfg_ff;
  logic                protect_ff;
  logic [7:0]          test_ff;
  logic [REF_DIVIDER_W-1:0] ref_divider_ff;
  logic [INT_W-1:0]    int_status_ff;
  logic [INT_W-1:0]    int_mask_ff;
  logic                lock_flag_ff;
  logic                osc_up_ff;
  logic [REF_DIVIDER_W-1:0] div_cnt_ff;
  logic                ref_clk_ff;
  logic                mon_reset_ff;

  reg_sel_t            wr_sel;
  reg_sel_t            rd_sel;
  logic                wr_fire;
  logic                wr_byte;
  logic                osc_wr_ok;
  logic                cfg_protect_bit_wr;
  logic                test_wr_ok;
  logic                ref_divider_wr_ok;
  logic [INT_W-1:0]    int_events;
  logic                osc_en;
  logic [31:0]         nxt_rdata;

  assign wr_sel  = decode(awaddr_ff);
  assign rd_sel  = decode(s_axi_araddr);
  assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
  // Only the low byte lane reaches the 8-bit registers
  assign wr_byte = wr_fire && wlane0_ff;
  assign osc_en  = osc_cfg_ff.osc_enable;

  assign osc_wr_ok    = wr_byte && wr_sel == SEL_OSC && !protect_ff && pll_clock_select;
  assign cfg_protect_bit_wr      = wr_byte && wr_sel == SEL_PROTECT;
  assign test_wr_ok   = wr_byte && wr_sel == SEL_TEST && special_mode;
  assign ref_divider_wr_ok = wr_byte && wr_sel == SEL_REF_DIVIDER && !protect_ff;

  assign s_axi_awready = !aw_held_ff;
  assign s_axi_wready  = !w_held_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  // Write address and data are latched independently, in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_ff <= 1'b0;
      awaddr_ff  <= '0;
    end
    else if (s_axi_awvalid && !aw_held_ff)
    begin
      aw_held_ff <= 1'b1;
      awaddr_ff  <= s_axi_awaddr;
    end
    else if (wr_fire)
      aw_held_ff <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held_ff <= 1'b0;
      wbyte_ff  <= 8'h00;
      wlane0_ff <= 1'b0;
    end
    else if (s_axi_wvalid && !w_held_ff)
    begin
      w_held_ff <= 1'b1;
      wbyte_ff  <= s_axi_wdata[7:0];
      wlane0_ff <= s_axi_wstrb[0];
    end
    else if (wr_fire)
      w_held_ff <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    else if (s_axi_bready)
      bvalid_ff <= 1'b0;
  end

  always_comb
  begin
    nxt_rdata = 32'h0000_0000;
    case (rd_sel)
      SEL_OSC:     nxt_rdata[7:0] = osc_cfg_ff;
      SEL_PROTECT: nxt_rdata[0] = protect_ff;
      SEL_TEST:    nxt_rdata[7:0] = test_ff;
      SEL_REF_DIVIDER:  nxt_rdata[REF_DIVIDER_W-1:0] = ref_divider_ff;
      SEL_STATUS:  nxt_rdata[INT_W+1:0] = {osc_up_ff, lock_flag_ff, int_status_ff};
      SEL_MASK:    nxt_rdata[INT_W-1:0] = int_mask_ff;
      default:     nxt_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= RESP_OKAY;
    end
    else if (s_axi_arvalid && !rvalid_ff)
    begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= nxt_rdata;
      rresp_ff  <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    else if (s_axi_rready)
      rvalid_ff <= 1'b0;
  end

  // Reserved bits are stored as written; software must keep them at reset value
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      osc_cfg_ff <= OSC_CONFIG_RST;
    else if (osc_wr_ok)
      osc_cfg_ff <= wbyte_ff;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      protect_ff <= PROTECT_RST;
    else if (cfg_protect_bit_wr)
      protect_ff <= (wbyte_ff != UNLOCK_KEY);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      test_ff <= FACTORY_TEST_RST;
    else if (test_wr_ok)
      test_ff <= wbyte_ff;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ref_divider_ff <= REF_DIVIDE_RST;
    else if (ref_divider_wr_ok)
      ref_divider_ff <= wbyte_ff[REF_DIVIDER_W-1:0];
  end

  // Reconfiguring the oscillator invalidates lock and stability; the clear wins here
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      lock_flag_ff <= 1'b0;
    else if (osc_wr_ok)
      lock_flag_ff <= 1'b0;
    else
      lock_flag_ff <= clk_status.pll_locked;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      osc_up_ff <= 1'b0;
    else if (osc_wr_ok)
      osc_up_ff <= 1'b0;
    else
      osc_up_ff <= osc_en && clk_status.osc_stable;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mon_reset_ff <= 1'b0;
    else
      mon_reset_ff <= osc_en && clk_status.osc_loss;
  end

  // Divide-by-(n+1) counter on oscillator ticks
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      div_cnt_ff <= '0;
      ref_clk_ff <= 1'b0;
    end
    else if (!osc_en)
    begin
      div_cnt_ff <= '0;
      ref_clk_ff <= internal_rc_clock;
    end
    else if (osc_output_clock)
    begin
      ref_clk_ff <= (div_cnt_ff == ref_divider_ff);
      div_cnt_ff <= (div_cnt_ff == ref_divider_ff) ? '0 : div_cnt_ff + 1'b1;
    end
    else
      ref_clk_ff <= 1'b0;
  end

  assign int_events[FLAG_LOCK_BIT] = !osc_wr_ok && clk_status.pll_locked && !lock_flag_ff;
  assign int_events[FLAG_UP_BIT]   = !osc_wr_ok && osc_en && clk_status.osc_stable && !osc_up_ff;
  assign int_events[MON_EVENT_BIT] = osc_en && clk_status.osc_loss && !mon_reset_ff;

  // Set beats write-one-to-clear in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      int_status_ff <= INT_STATUS_RST;
    else if (wr_byte && wr_sel == SEL_STATUS)
      int_status_ff <= (int_status_ff & ~wbyte_ff[INT_W-1:0]) | int_events;
    else
      int_status_ff <= int_status_ff | int_events;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      int_mask_ff <= INT_MASK_RST;
    else if (wr_byte && wr_sel == SEL_MASK)
      int_mask_ff <= wbyte_ff[INT_W-1:0];
  end

  assign crystal_oscillator_enable = osc_en;
  assign clock_monitor_enable      = osc_en;
  assign osc_qualify_enable        = osc_en && pll_clock_select;
  assign reference_clock           = ref_clk_ff;
  assign clock_monitor_reset       = mon_reset_ff;
  assign osc_clock_allowed         = osc_up_ff;
  assign cfg_write_enable          = !protect_ff;
  assign ref_divider               = ref_divider_ff;
  assign factory_test_value        = test_ff;
  assign irq                       = |(int_status_ff & int_mask_ff);

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_osc_write_blocked: assert property (
    (wr_byte && wr_sel == SEL_OSC && (protect_ff || !pll_clock_select)) |=> $stable(osc_cfg_ff))
    else $error("oscillator config changed while write was blocked");

  a_osc_write_taken: assert property (
    osc_wr_ok |=> osc_cfg_ff == $past(wbyte_ff))
    else $error("accepted oscillator config write not stored");

  a_write_clears_flags: assert property (
    osc_wr_ok |=> !lock_flag_ff && !osc_up_ff)
    else $error("lock or up flag survived oscillator config write");

  a_rc_reference_path: assert property (
    (!osc_en && $past(!osc_en)) |-> reference_clock == $past(internal_rc_clock))
    else $error("reference not following rc clock with oscillator off");

  a_undivided_reference: assert property (
    (osc_en && ref_divider_ff == '0 && osc_output_clock && !osc_wr_ok && !ref_divider_wr_ok)
      |=> reference_clock)
    else $error("reference tick missing at divide by one");

  a_divider_spacing: assert property (
    (osc_en && reference_clock && ref_divider_ff != '0 && $stable(ref_divider_ff))
      |-> div_cnt_ff == '0)
    else $error("divider counter not restarted after reference tick");

  a_monitor_reset: assert property (
    (osc_en && clk_status.osc_loss) |=> clock_monitor_reset)
    else $error("clock monitor reset not raised on oscillation loss");

  a_up_flag_set: assert property (
    (osc_en && clk_status.osc_stable && !osc_wr_ok) |=> osc_clock_allowed)
    else $error("oscillator up flag not set when stable");

  a_key_unlocks: assert property (
    (cfg_protect_bit_wr && wbyte_ff == UNLOCK_KEY) |=> !protect_ff ##0 cfg_write_enable)
    else $error("key write did not clear protection");

  a_bad_key_locks: assert property (
    (cfg_protect_bit_wr && wbyte_ff != UNLOCK_KEY) |=> protect_ff)
    else $error("non-key write did not set protection");

  a_test_write_ignored: assert property (
    (wr_byte && wr_sel == SEL_TEST && !special_mode) |=> $stable(test_ff))
    else $error("factory test register written outside special mode");

  c_unlock_then_enable: cover property (
    (cfg_protect_bit_wr && wbyte_ff == UNLOCK_KEY) ##[1:20] (osc_wr_ok && wbyte_ff[OSC_ENABLE_BIT]));
  c_osc_up: cover property (osc_en ##[1:50] osc_clock_allowed);
  c_monitor_reset: cover property (clock_monitor_reset);
  c_irq_raised: cover property (!irq ##1 irq);

endmodule

`default_nettype wire

// *** sim/osc_xtal_model.sv ***
`timescale 1ns/100ps
`default_nettype none

module osc_xtal_model #(
  parameter int STARTUP = 8
)
(
  input  wire logic aclk,
  input  wire logic enable,
  input  wire logic lose,
  output logic      tick,
  output logic      stable,
  output logic      loss
);
  int run_ff;
  bit tick_ff;

  // Crystal stands still while disabled or lost, so ticks stop too
  always_ff @(posedge aclk)
  begin
    if (!enable || lose)
      run_ff <= 0;
    else if (run_ff < STARTUP)
      run_ff <= run_ff + 1;
    tick_ff <= enable && !lose && !tick_ff;
  end

  assign tick   = tick_ff;
  assign stable = (run_ff >= STARTUP);
  assign loss   = enable && lose;
endmodule

`default_nettype wire

// *** sim/tb.sv ***
`timescale 1ns/100ps
`default_nettype none

module tb
  import osc_cfg_pkg::*;
;
  logic              aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic              s_axi_rready, pll_clock_select, special_mode, internal_rc_clock, irq;
  logic              osc_output_clock, crystal_oscillator_enable, clock_monitor_enable, lose;
  logic              osc_qualify_enable, reference_clock, clock_monitor_reset, pll_locked;
  logic              osc_clock_allowed, cfg_write_enable, stable, loss, up_at_b;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0]       s_axi_wdata, s_axi_rdata, d;
  logic [3:0]        s_axi_wstrb, ref_divider;
  logic [1:0]        s_axi_bresp, s_axi_rresp, resp;
  logic [7:0]        factory_test_value, v;
  clk_status_t       clk_status;
  int                errors, n_tests, m_osc, m_cfg_protect_bit, m_test, m_div, n_tick, n_ref, n_mon, t0, r0;

  assign clk_status = {loss, stable, pll_locked};

  osc_config_and_write_protect osc_config_and_write_protect_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pll_clock_select, .special_mode,
    .clk_status, .internal_rc_clock, .osc_output_clock, .crystal_oscillator_enable,
    .clock_monitor_enable, .osc_qualify_enable, .reference_clock, .clock_monitor_reset,
    .osc_clock_allowed, .cfg_write_enable, .ref_divider, .factory_test_value, .irq);

  osc_xtal_model osc_xtal_model_inst (
    .aclk, .enable(crystal_oscillator_enable), .lose, .tick(osc_output_clock), .stable, .loss);

  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  always @(posedge aclk)
  begin
    n_tick += osc_output_clock;
    n_ref  += reference_clock;
    n_mon  += clock_monitor_reset;
  end

  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Holds each channel until its own handshake; bounded so a hang ends the run
  task automatic wr(input logic [9:0] idx, input logic [7:0] dat);
    int i;
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {24'h0, dat};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    resp = s_axi_bresp;
    up_at_b = osc_clock_allowed;
    s_axi_bready <= 1'b0;
    if (i == 50) errors++;
    if (i == 50) wrap_up();
    @(posedge aclk);
  endtask

  task automatic rd(input logic [9:0] idx);
    int i;
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (i == 50) errors++;
    if (i == 50) wrap_up();
    @(posedge aclk);
  endtask

  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {special_mode, internal_rc_clock, pll_locked, lose} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'h1;
    pll_clock_select = 1'b1;
    void'($urandom(88282));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int k = 0; k < 6; k++)
    begin
      rd(IDX_OSC_CONFIG + 10'(k));
      chk(d, 0, "reset value");
    end
    rd(10'h100);
    chk(d, 0, "unmapped data");
    chk(resp, RESP_SLVERR, "unmapped read resp");
    wr(10'h100, 8'h55);
    chk(resp, RESP_SLVERR, "unmapped write resp");
    $display("test reset done");
    for (int k = 0; k < 6; k++)
    begin
      v = (k % 2) ? 8'($urandom) : UNLOCK_KEY;
      if (k % 2 && v == UNLOCK_KEY) v = 8'h00;
      wr(IDX_CLK_PROTECT, v);
      chk(resp, RESP_OKAY, "write resp");
      m_cfg_protect_bit = (v != UNLOCK_KEY);
      rd(IDX_CLK_PROTECT);
      chk(d, m_cfg_protect_bit, "protect bit");
      chk(cfg_write_enable, !m_cfg_protect_bit, "write enable");
    end
    $display("test protect done");
    for (int k = 0; k < 8; k++)
    begin
      wr(IDX_CLK_PROTECT, k[0] ? 8'h00 : UNLOCK_KEY);
      pll_clock_select <= k[1];
      repeat (20) @(posedge aclk);
      v = 8'(m_osc) ^ 8'h80;
      wr(IDX_OSC_CONFIG, v);
      if (!k[0] && k[1]) chk(up_at_b, 0, "flag clear");
      if (!k[0] && k[1]) m_osc = v;
      rd(IDX_OSC_CONFIG);
      chk(d, m_osc, "osc config");
      chk({crystal_oscillator_enable, clock_monitor_enable}, {2{m_osc[7]}}, "osc on");
      chk(osc_qualify_enable, m_osc[7] & k[1], "qualify");
      v = 8'($urandom % 16);
      wr(IDX_REF_DIVIDE, v);
      if (!k[0]) m_div = v;
      chk(ref_divider, m_div, "divider");
    end
    pll_clock_select <= 1'b1;
    wr(IDX_CLK_PROTECT, UNLOCK_KEY);
    s_axi_wstrb <= 4'h0;
    wr(IDX_OSC_CONFIG, 8'h80);
    chk(resp, RESP_OKAY, "strobe off resp");
    chk(crystal_oscillator_enable, 0, "strobe off");
    s_axi_wstrb <= 4'h1;
    wr(IDX_OSC_CONFIG, 8'h00);
    $display("test gating done");
    for (int k = 0; k < 20; k++)
    begin
      @(posedge aclk);
      if (k > 1) chk(reference_clock, v[0], "rc ref");
      v[0] = internal_rc_clock;
      internal_rc_clock <= 1'($urandom);
    end
    m_div = $urandom % 16;
    wr(IDX_REF_DIVIDE, 8'(m_div));
    wr(IDX_OSC_CONFIG, 8'h80);
    t0 = n_tick;
    r0 = n_ref;
    repeat (200) @(posedge aclk);
    t0 = n_tick - t0;
    r0 = (n_ref - r0) * (m_div + 1);
    chk(r0 <= t0 + m_div + 1 && r0 + m_div + 1 >= t0, 1, "ref rate");
    chk(osc_clock_allowed, 1, "osc up");
    $display("test reference done");
    pll_locked <= 1'b1;
    // Lock flag follows its input one cycle later
    @(posedge aclk);
    rd(IDX_INT_STATUS);
    chk(d[4:3], 2'b11, "live flags");
    pll_locked <= 1'b0;
    @(posedge aclk);
    rd(IDX_INT_STATUS);
    chk(d[3], 0, "lock drop");
    wr(IDX_INT_MASK, 8'h00);
    for (int k = 0; k < 2; k++)
    begin
      t0 = n_mon;
      lose <= 1'b1;
      repeat (3) @(posedge aclk);
      lose <= 1'b0;
      repeat (3) @(posedge aclk);
      chk(n_mon - t0, k ? 0 : 3, "monitor reset");
      chk(irq, 0, "masked irq");
      wr(IDX_OSC_CONFIG, 8'h00);
    end
    wr(IDX_INT_MASK, 8'h04);
    chk(irq, 1, "irq on");
    wr(IDX_INT_STATUS, 8'h04);
    rd(IDX_INT_STATUS);
    chk({d[2], irq}, 0, "irq clear");
    $display("test monitor done");
    for (int k = 0; k < 4; k++)
    begin
      special_mode <= k[0];
      v = 8'($urandom);
      wr(IDX_FACTORY_TEST, v);
      if (k[0]) m_test = v;
      rd(IDX_FACTORY_TEST);
      chk(d, m_test, "factory test read");
      chk(factory_test_value, m_test, "factory test value");
    end
    $display("test factory done");
    wrap_up();
  end
endmodule

`default_nettype wire
